/* rtl/spi_link_pkg.sv */
// constants and types shared by both ends of the host serial link
// What this block does
// [RULE1] reset, then detect interface before any transfer
// [RULE2] straps pick uart, spi or two-wire mode
// [RULE3] device is spi slave, up to 10 mbit/s
// [RULE4] master alone generates the serial clock
// [RULE5] every byte shifted most significant bit first
// [RULE6] master changes data on falling edge only; the code drives the first bit in the cycle select goes low
// [RULE7] device changes its output on falling edge
// [RULE8] first byte carries direction and register address
// [RULE9] read: address per byte, 00 ends, one-byte lag
// [RULE10] write: one address, many data, output don't-care
// [RULE11] address bit 7 set means read, clear write
// [RULE12] bits 6..1 address, bit 0 sent as 0
// [RULE13] uart mode: line enable clear releases two outputs
// [RULE14] select low frames transfer; high restarts decoding
// [RULE15] burst write data all go to one register
package spi_link_pkg;

  // -----------------------------------------------------------------
  // interface modes
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {IF_UART, IF_SPI, IF_I2C} host_if_e;

  // -----------------------------------------------------------------
  // address byte layout
  // -----------------------------------------------------------------
  localparam int DIR_BIT = 7;
  localparam int ADDR_MSB = 6;
  localparam int ADDR_LSB = 1;
  localparam logic DIR_READ = 1'b1;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic [7:0] END_BYTE = 8'h00;
  localparam int REG_COUNT = 64;

  // -----------------------------------------------------------------
  // line enable control register
  // -----------------------------------------------------------------
  localparam logic [5:0] TPE_ADDR = 6'h33;
  localparam int SLE_BIT = 7;
  localparam logic [7:0] TPE_RESET = 8'h80;
  localparam logic [7:0] REG_RESET = 8'h00;

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  // strap sampling waits for the two synchroniser stages plus one
  localparam logic [1:0] DETECT_CYCLES = 2'h3;
  // host clock half period, 4 cycles of 100 ns gives an 800 ns clock
  localparam int SCK_HALF_NS = 400;
  localparam logic [2:0] SCK_HALF_CYCLES = 3'(SCK_HALF_NS / CLK_PERIOD_NS);
  localparam logic [2:0] GAP_CYCLES = 3'h4;

endpackage

/* rtl/spi_link_if.sv */
// wires of the four-line serial link between host and device
`timescale 1ns/100ps
interface spi_link_if;
  logic sck;
  logic nss_n;
  logic mosi;
  logic miso;
  logic miso_oe;

  modport device
  (
    input sck,
    input nss_n,
    input mosi,
    output miso,
    output miso_oe
  );

  modport host
  (
    output sck,
    output nss_n,
    output mosi,
    input miso,
    input miso_oe
  );
endinterface // spi_link_if

/* rtl/host_if_detect_spi_dev.sv */
// device end: strap detection, spi slave and register file
`timescale 1ns/100ps
module host_if_detect_spi_dev
  import spi_link_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  spi_link_if.device link,
  input wire logic i2c_sel_strap,
  input wire logic spi_sel_strap,
  input wire logic data_request_src,
  input wire logic aux_mux_src,
  output host_if_e detected_if,
  output logic detect_done,
  output logic twowire_address_extend,
  output logic reg_wr_pulse,
  output logic [5:0] reg_wr_addr,
  output logic [7:0] reg_wr_data,
  output logic serial_line_enable,
  output logic uart_data_request,
  output logic uart_data_request_oe,
  output logic uart_aux_mux_out,
  output logic uart_aux_mux_out_oe
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [REG_COUNT-1:0][7:0] regs;
    host_if_e mode;
    logic done;
    logic [1:0] det_cnt;
    logic addr_ext;
    logic i2c_s1;
    logic i2c_s2;
    logic spi_s1;
    logic spi_s2;
    logic sck_s1;
    logic sck_s2;
    logic sck_p;
    logic nss_s1;
    logic nss_s2;
    logic mosi_s1;
    logic mosi_s2;
    logic [2:0] bit_cnt;
    logic first_byte;
    logic is_read;
    logic [5:0] addr;
    logic [6:0] rx;
    logic [7:0] tx;
    logic miso;
    logic miso_oe;
    logic wr_pulse;
    logic [5:0] wr_addr;
    logic [7:0] wr_data;
    logic dreq;
    logic dreq_oe;
    logic mux;
    logic mux_oe;
  } dev_s;

  dev_s q;
  dev_s d;

  function automatic logic [5:0] addr_of(input logic [7:0] b);
    return b[ADDR_MSB:ADDR_LSB];
  endfunction

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb
  begin
    logic rise;
    logic fall;
    logic active;
    logic [7:0] byte_in;
    logic uart_on;
    rise = 1'b0;
    fall = 1'b0;
    active = 1'b0;
    byte_in = 8'h00;
    uart_on = 1'b0;
    d = q;
    d.wr_pulse = 1'b0;

    // pins from the far side pass two flops before any use
    d.sck_s1 = link.sck;
    d.sck_s2 = q.sck_s1;
    d.nss_s1 = link.nss_n;
    d.nss_s2 = q.nss_s1;
    d.mosi_s1 = link.mosi;
    d.mosi_s2 = q.mosi_s1;
    d.i2c_s1 = i2c_sel_strap;
    d.i2c_s2 = q.i2c_s1;
    d.spi_s1 = spi_sel_strap;
    d.spi_s2 = q.spi_s1;
    d.sck_p = q.sck_s2;

    // the clock is only ever observed, never driven here
    rise = q.sck_s2 & ~q.sck_p; // [RULE4]
    fall = ~q.sck_s2 & q.sck_p;

    // straps are taken once the synchronisers have settled
    if (!q.done)
    begin
      d.det_cnt = q.det_cnt + 2'h1;
      if (q.det_cnt == DETECT_CYCLES - 2'h1)
      begin
        d.done = 1'b1; // [RULE1]
        if (q.i2c_s2)
        begin
          d.mode = IF_I2C; // [RULE2]
          d.addr_ext = q.spi_s2; // [RULE2]
        end
        else if (q.spi_s2)
        begin
          d.mode = IF_SPI; // [RULE2]
        end
        else
        begin
          d.mode = IF_UART; // [RULE2]
        end
      end
    end

    // no transfer is served before the mode is known
    active = q.done & (q.mode == IF_SPI) & ~q.nss_s2; // [RULE1]

    if (!active)
    begin
      // select high clears all framing state
      d.bit_cnt = 3'h0; // [RULE14]
      d.first_byte = 1'b1; // [RULE14]
      d.is_read = 1'b0;
      d.tx = 8'h00;
      d.miso = 1'b0;
      d.miso_oe = 1'b0;
    end
    else
    begin
      // slave only: the data-out line is ours while selected
      d.miso_oe = 1'b1; // [RULE3]
      if (rise)
      begin
        // sample on the rising edge, msb arrives first
        d.rx = {q.rx[5:0], q.mosi_s2}; // [RULE5] [RULE6]
        d.bit_cnt = q.bit_cnt + 3'h1;
        if (q.bit_cnt == 3'h7)
        begin
          byte_in = {q.rx, q.mosi_s2};
          d.first_byte = 1'b0;
          if (q.first_byte)
          begin
            // the opening byte alone fixes direction, and the address of a write
            d.is_read = (byte_in[DIR_BIT] == DIR_READ); // [RULE8] [RULE11]
            d.addr = addr_of(byte_in); // [RULE8] [RULE12]
            if (byte_in[DIR_BIT] == DIR_READ)
            begin
              d.tx = q.regs[addr_of(byte_in)]; // [RULE9]
            end
            else
            begin
              d.tx = 8'h00; // [RULE10]
            end
          end
          else if (q.is_read)
          begin
            // each further byte names the next register to return;
            // the closing 00 just loads a value nobody reads
            d.addr = addr_of(byte_in); // [RULE9]
            d.tx = q.regs[addr_of(byte_in)]; // [RULE9]
          end
          else
          begin
            // burst data all land in the one register, no increment
            d.regs[q.addr] = byte_in; // [RULE15]
            d.wr_pulse = 1'b1;
            d.wr_addr = q.addr; // [RULE15]
            d.wr_data = byte_in;
          end
        end
      end
      else if (fall)
      begin
        // output changes on the falling edge, msb first
        d.miso = q.tx[7]; // [RULE7] [RULE5]
        d.tx = {q.tx[6:0], 1'b0}; // [RULE7]
      end
    end

    // uart side lines are released when the line enable is cleared
    uart_on = q.done & (q.mode == IF_UART);
    d.dreq = data_request_src;
    d.mux = aux_mux_src;
    d.dreq_oe = uart_on & q.regs[TPE_ADDR][SLE_BIT]; // [RULE13]
    d.mux_oe = uart_on & q.regs[TPE_ADDR][SLE_BIT]; // [RULE13]

    if (sys_rst)
    begin
      d = '0;
      for (int i = 0; i < REG_COUNT; i++)
      begin
        d.regs[i] = REG_RESET;
      end
      d.regs[TPE_ADDR] = TPE_RESET;
      d.mode = IF_UART;
      d.first_byte = 1'b1;
      d.nss_s1 = 1'b1;
      d.nss_s2 = 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // register
  // -----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    q <= d;
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign link.miso = q.miso;
  assign link.miso_oe = q.miso_oe;
  assign detected_if = q.mode;
  assign detect_done = q.done;
  assign twowire_address_extend = q.addr_ext;
  assign reg_wr_pulse = q.wr_pulse;
  assign reg_wr_addr = q.wr_addr;
  assign reg_wr_data = q.wr_data;
  assign serial_line_enable = q.regs[TPE_ADDR][SLE_BIT];
  assign uart_data_request = q.dreq;
  assign uart_data_request_oe = q.dreq_oe;
  assign uart_aux_mux_out = q.mux;
  assign uart_aux_mux_out_oe = q.mux_oe;

endmodule // host_if_detect_spi_dev

/* rtl/host_spi_master.sv */
// host end: spi master that issues register reads and burst writes
`timescale 1ns/100ps
module host_spi_master
  import spi_link_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  spi_link_if.host link,
  input wire logic cmd_valid,
  input wire logic cmd_is_read,
  input wire logic [5:0] cmd_addr,
  input wire logic [3:0] cmd_len,
  input wire logic [7:0] cmd_wdata,
  output logic cmd_ready,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic done
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef enum {ST_IDLE, ST_SETUP, ST_LOW, ST_HIGH, ST_GAP} hst_e;

  typedef struct packed {
    hst_e st;
    logic [2:0] cnt;
    logic [2:0] bit_cnt;
    logic [4:0] byte_idx;
    logic is_read;
    logic [5:0] addr;
    logic [3:0] len;
    logic [7:0] wdata;
    logic [7:0] tx;
    logic [7:0] rx;
    logic sck;
    logic nss_n;
    logic mosi;
    logic miso_s1;
    logic miso_s2;
    logic ready;
    logic rd_valid;
    logic [7:0] rd_data;
    logic done;
  } host_s;

  host_s q;
  host_s d;

  // byte k of the transfer as sent on the data-out line
  function automatic logic [7:0] out_byte(input logic rd,
                                          input logic [5:0] a,
                                          input logic [3:0] n,
                                          input logic [7:0] w,
                                          input logic [4:0] k);
    logic [5:0] ak;
    ak = a + {1'b0, k};
    if (rd)
    begin
      // one address byte per data byte, then the closing 00
      if (k == {1'b0, n})
      begin
        return END_BYTE; // [RULE9]
      end
      return {DIR_READ, ak, 1'b0}; // [RULE11] [RULE12]
    end
    if (k == 5'h00)
    begin
      return {DIR_WRITE, a, 1'b0}; // [RULE8] [RULE11] [RULE12]
    end
    return w; // [RULE10]
  endfunction

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb
  begin
    logic [7:0] nb;
    nb = 8'h00;
    d = q;
    d.rd_valid = 1'b0;
    d.done = 1'b0;
    d.miso_s1 = link.miso;
    d.miso_s2 = q.miso_s1;
    d.cnt = q.cnt + 3'h1;

    case (q.st)
      ST_IDLE:
      begin
        d.cnt = 3'h0;
        d.ready = 1'b1;
        if (cmd_valid && q.ready)
        begin
          d.ready = 1'b0;
          d.is_read = cmd_is_read;
          d.addr = cmd_addr;
          d.len = (cmd_len == 4'h0) ? 4'h1 : cmd_len;
          d.wdata = cmd_wdata;
          d.byte_idx = 5'h00;
          d.bit_cnt = 3'h0;
          // use the adjusted length so a zero length still sends an address
          d.tx = out_byte(cmd_is_read, cmd_addr, d.len, cmd_wdata,
                          5'h00);
          d.mosi = d.tx[7];
          d.nss_n = 1'b0; // [RULE14]
          d.st = ST_SETUP;
        end
      end
      ST_SETUP, ST_LOW:
      begin
        if (q.cnt == SCK_HALF_CYCLES - 3'h1)
        begin
          d.cnt = 3'h0;
          // data has stood a half period before this rising edge
          d.sck = 1'b1; // [RULE4] [RULE6]
          d.st = ST_HIGH;
        end
      end
      ST_HIGH:
      begin
        if (q.cnt == SCK_HALF_CYCLES - 3'h1)
        begin
          // sample late in the high phase: the device answers a few
          // of its own cycles after the falling edge
          d.cnt = 3'h0;
          d.rx = {q.rx[6:0], q.miso_s2}; // [RULE5]
          d.sck = 1'b0; // [RULE4]
          d.bit_cnt = q.bit_cnt + 3'h1;
          d.tx = {q.tx[6:0], 1'b0};
          d.mosi = q.tx[6]; // [RULE6] [RULE5]
          d.st = ST_LOW;
          if (q.bit_cnt == 3'h7)
          begin
            if (q.is_read && q.byte_idx != 5'h00)
            begin
              d.rd_valid = 1'b1; // [RULE9]
              d.rd_data = {q.rx[6:0], q.miso_s2};
            end
            d.byte_idx = q.byte_idx + 5'h01;
            if (q.byte_idx == {1'b0, q.len})
            begin
              d.st = ST_GAP;
              d.mosi = 1'b0;
            end
            else
            begin
              nb = out_byte(q.is_read, q.addr, q.len, q.wdata,
                            q.byte_idx + 5'h01);
              d.tx = nb;
              d.mosi = nb[7]; // [RULE6]
            end
          end
        end
      end
      ST_GAP:
      begin
        if (q.cnt == SCK_HALF_CYCLES - 3'h1)
        begin
          d.nss_n = 1'b1; // [RULE14]
        end
        if (q.cnt == GAP_CYCLES + SCK_HALF_CYCLES - 3'h1)
        begin
          d.done = 1'b1;
          d.st = ST_IDLE;
        end
      end
      default:
      begin
        d.st = ST_IDLE;
      end
    endcase

    if (sys_rst)
    begin
      d = '0;
      d.st = ST_IDLE;
      d.nss_n = 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // register
  // -----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    q <= d;
  end

  assign link.sck = q.sck;
  assign link.nss_n = q.nss_n;
  assign link.mosi = q.mosi;
  assign cmd_ready = q.ready;
  assign rd_valid = q.rd_valid;
  assign rd_data = q.rd_data;
  assign done = q.done;

endmodule // host_spi_master

/* dv/spi_link_asserts.sv */
// wire-level assertions on the serial link between host and device
`timescale 1ns/100ps
module spi_link_asserts
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sck,
  input wire logic nss_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  logic [7:0] bits_q;
  logic rd_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // ------
  // bits of the current frame
  // ------
  always_ff @(posedge clk)
  begin
    if (sys_rst || nss_n)
    begin
      bits_q <= 8'h00;
      rd_q <= 1'b0;
    end
    else if ($rose(sck))
    begin
      bits_q <= bits_q + 8'h01;
      // first bit of a frame is the direction
      if (bits_q == 8'h00)
        rd_q <= mosi;
    end
  end

  // ------
  // properties
  // ------
  a_sck_idle_low: assert property (nss_n |-> !sck)
    else $error("serial clock high while deselected");
  a_sck_half_period: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
    else $error("serial clock high phase not four cycles");
  a_mosi_steady_high: assert property (sck && $past(sck) |-> $stable(mosi))
    else $error("master data moved while clock high");
  a_miso_steady_high: assert property (sck && $past(sck) |-> $stable(miso))
    else $error("device data moved while clock high");
  a_oe_release: assert property (nss_n [*4] |-> !miso_oe)
    else $error("device still drives after deselect");
  a_whole_bytes: assert property ($rose(nss_n) |-> bits_q[2:0] == 3'h0)
    else $error("frame ended inside a byte");
  a_addr_lsb_zero: assert property ($rose(sck) && bits_q == 8'h07 |-> !mosi)
    else $error("address byte bit 0 not zero");
  a_write_quiet: assert property (!rd_q && bits_q > 8'h01 |-> !miso)
    else $error("device data not quiet during write");
endmodule // spi_link_asserts

/* dv/tb_top.sv */
// bench joining host master and device over the serial link
`timescale 1ns/100ps
module tb_top;
  import spi_link_pkg::*;
  logic clk, sys_rst, i2c_sel_strap, spi_sel_strap;
  logic data_request_src, aux_mux_src, cmd_valid, cmd_is_read;
  logic [5:0] cmd_addr, reg_wr_addr;
  logic [3:0] cmd_len;
  logic [7:0] cmd_wdata, rd_data, reg_wr_data;
  logic cmd_ready, rd_valid, done, detect_done, twowire_address_extend;
  logic reg_wr_pulse, serial_line_enable, uart_data_request;
  logic uart_data_request_oe, uart_aux_mux_out, uart_aux_mux_out_oe;
  logic oe_seen;
  host_if_e detected_if;
  logic [7:0] got_q[$];
  logic [13:0] wr_q[$];
  int n_errors, comparisons;

  spi_link_if link();

  host_if_detect_spi_dev u_host_if_detect_spi_dev (.clk, .sys_rst,
    .link(link), .i2c_sel_strap, .spi_sel_strap, .data_request_src,
    .aux_mux_src, .detected_if, .detect_done, .twowire_address_extend,
    .reg_wr_pulse, .reg_wr_addr, .reg_wr_data, .serial_line_enable,
    .uart_data_request, .uart_data_request_oe, .uart_aux_mux_out,
    .uart_aux_mux_out_oe);

  host_spi_master u_host_spi_master (.clk, .sys_rst, .link(link),
    .cmd_valid, .cmd_is_read, .cmd_addr, .cmd_len, .cmd_wdata, .cmd_ready,
    .rd_valid, .rd_data, .done);

  spi_link_asserts u_spi_link_asserts (.clk, .sys_rst, .sck(link.sck),
    .nss_n(link.nss_n), .mosi(link.mosi), .miso(link.miso),
    .miso_oe(link.miso_oe));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ------
  // collectors and helpers
  // ------
  always @(negedge clk)
  begin
    if (rd_valid === 1'b1)
      got_q.push_back(rd_data);
    if (reg_wr_pulse === 1'b1)
      wr_q.push_back({reg_wr_addr, reg_wr_data});
    if (link.miso_oe === 1'b1)
      oe_seen = 1'b1;
  end

  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // straps are only looked at once after each reset
  task automatic do_reset(input logic i2c, input logic spi);
    @(negedge clk);
    i2c_sel_strap = i2c;
    spi_sel_strap = spi;
    sys_rst = 1'b1;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    check_val(8'(detect_done), 8'h01);
  endtask

  task automatic run_cmd(input logic rd, input logic [5:0] a,
    input logic [3:0] n, input logic [7:0] w);
    int t;
    got_q.delete();
    wr_q.delete();
    oe_seen = 1'b0;
    check_val(8'(cmd_ready), 8'h01);
    cmd_is_read = rd;
    cmd_addr = a;
    cmd_len = n;
    cmd_wdata = w;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    t = 0;
    while (done !== 1'b1 && t < 4000)
    begin
      @(negedge clk);
      t++;
    end
    if (t >= 4000)
      n_errors++;
    repeat (2) @(negedge clk);
  endtask

  // ------
  // scenarios
  // ------
  task automatic test_uart;
    do_reset(1'b0, 1'b0);
    data_request_src = 1'b1;
    aux_mux_src = 1'b1;
    repeat (2) @(negedge clk);
    check_val(8'(detected_if), 8'(IF_UART));
    check_val(8'(uart_data_request), 8'h01);
    check_val(8'(uart_data_request_oe), 8'h01);
    check_val(8'(uart_aux_mux_out_oe), 8'h01);
    check_val(8'(uart_aux_mux_out), 8'h01);
    run_cmd(1'b0, 6'h05, 4'h1, 8'h5a);
    check_val(8'(wr_q.size()), 8'h00);
    check_val(8'(oe_seen), 8'h00);
  endtask

  task automatic test_twowire;
    do_reset(1'b1, 1'b1);
    check_val(8'(detected_if), 8'(IF_I2C));
    check_val(8'(twowire_address_extend), 8'h01);
    check_val(8'(uart_data_request_oe), 8'h00);
    check_val(8'(uart_aux_mux_out_oe), 8'h00);
    // straps moving after detection must not change the mode
    i2c_sel_strap = 1'b0;
    repeat (4) @(negedge clk);
    check_val(8'(detected_if), 8'(IF_I2C));
    do_reset(1'b1, 1'b0);
    check_val(8'(twowire_address_extend), 8'h00);
  endtask

  task automatic test_spi;
    do_reset(1'b0, 1'b1);
    check_val(8'(detected_if), 8'(IF_SPI));
    run_cmd(1'b0, 6'h05, 4'h3, 8'ha5);
    check_val(8'(wr_q.size()), 8'h03);
    check_val(8'(oe_seen), 8'h01);
    foreach (wr_q[i])
    begin
      check_val(8'(wr_q[i][13:8]), 8'h05);
      check_val(wr_q[i][7:0], 8'ha5);
    end
    run_cmd(1'b1, 6'h04, 4'h3, 8'h00);
    check_val(8'(got_q.size()), 8'h03);
    check_val(got_q[0], 8'h00);
    check_val(got_q[1], 8'ha5);
    check_val(got_q[2], 8'h00);
    run_cmd(1'b1, 6'h32, 4'h2, 8'h00);
    check_val(got_q[1], TPE_RESET);
    run_cmd(1'b0, TPE_ADDR, 4'h1, 8'h00);
    check_val(8'(serial_line_enable), 8'h00);
    // a zero length command is served as one data byte
    run_cmd(1'b0, 6'h07, 4'h0, 8'h3c);
    check_val(8'(wr_q.size()), 8'h01);
    check_val(wr_q[0][7:0], 8'h3c);
  endtask

  initial
  begin
    sys_rst = 1'b1;
    i2c_sel_strap = 1'b0;
    spi_sel_strap = 1'b0;
    data_request_src = 1'b0;
    aux_mux_src = 1'b0;
    cmd_valid = 1'b0;
    cmd_is_read = 1'b0;
    cmd_addr = 6'h00;
    cmd_len = 4'h0;
    cmd_wdata = 8'h00;
    n_errors = 0;
    comparisons = 0;
    test_uart();
    test_twowire();
    test_spi();
    stop_test();
  end

  // a full run is some 1200 cycles; the 20000-cycle limit allows ample margin
  initial
  begin
    #2000000;
    n_errors++;
    stop_test();
  end
endmodule // tb_top
